// >>> byte_alu_pkg.sv
// Shared constants and types of the byte ALU datapath
package byte_alu_pkg;

	// Register byte offsets on the APB
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_DST    = 12'h004;
	localparam logic [11:0] OFF_SRC    = 12'h008;
	localparam logic [11:0] OFF_IMM    = 12'h00c;
	localparam logic [11:0] OFF_CCR    = 12'h010;
	localparam logic [11:0] OFF_STATUS = 12'h014;

	// Register select codes
	localparam logic [2:0] SEL_CTRL   = 3'h0;
	localparam logic [2:0] SEL_DST    = 3'h1;
	localparam logic [2:0] SEL_SRC    = 3'h2;
	localparam logic [2:0] SEL_IMM    = 3'h3;
	localparam logic [2:0] SEL_CCR    = 3'h4;
	localparam logic [2:0] SEL_STATUS = 3'h5;
	localparam logic [2:0] SEL_NONE   = 3'h7;

	// Control register fields
	localparam int CTRL_OP_LSB  = 0;
	localparam int CTRL_WORD    = 8;
	localparam int CTRL_USE_IMM = 9;

	// Condition code bit positions
	localparam int CCR_N = 3;
	localparam int CCR_Z = 2;
	localparam int CCR_V = 1;
	localparam int CCR_C = 0;

	// Status bit positions
	localparam int STAT_BUSY    = 0;
	localparam int STAT_ILLEGAL = 1;
	localparam int STAT_DIV_ERR = 2;

	// Reset values
	localparam logic [15:0] RST_DST  = 16'h0000;
	localparam logic [15:0] RST_SRC  = 16'h0000;
	localparam logic [7:0]  RST_IMM  = 8'h00;
	localparam logic [3:0]  RST_CCR  = 4'h0;
	localparam logic [4:0]  RST_OP   = 5'h00;

	// Divider iterations, one quotient bit each
	localparam logic [3:0] DIV_STEPS = 4'h8;

	typedef enum logic [4:0] {
		decimal_adjust_add = 5'h00,
		decimal_adjust_sub = 5'h01,
		unsigned_multiply  = 5'h02,
		unsigned_divide    = 5'h03,
		compare_op         = 5'h04,
		negate_op          = 5'h05,
		and_op             = 5'h06,
		or_op              = 5'h07,
		xor_op             = 5'h08,
		not_op             = 5'h09,
		arith_shift_left   = 5'h0a,
		arith_shift_right  = 5'h0b,
		logic_shift_left   = 5'h0c,
		logic_shift_right  = 5'h0d,
		rotate_left        = 5'h0e,
		rotate_right       = 5'h0f,
		rotate_carry_left  = 5'h10,
		rotate_carry_right = 5'h11
	} alu_op_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_EXEC   = 3'b010,
		ST_DIVIDE = 3'b100
	} alu_state_t;

endpackage : byte_alu_pkg

// >>> div_if.sv
// Handshake between the ALU control and the iterative divider
`timescale 1ns/1ps
interface div_if;
	logic        start;
	logic [15:0] dividend;
	logic [7:0]  divisor;
	logic        done;
	logic [7:0]  quotient;
	logic [7:0]  remainder;

	modport ctrl (output start, dividend, divisor,
		input done, quotient, remainder);
	modport unit (input start, dividend, divisor,
		output done, quotient, remainder);
endinterface : div_if

// >>> byte_divider.sv
// Restoring 16 by 8 unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
module byte_divider (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Divide request and result
	div_if.unit      dv
);

	typedef struct packed {
		logic       busy;
		logic       done;
		logic [3:0] count;
		logic [8:0] part;
		logic [7:0] low;
		logic [7:0] divisor;
		logic [7:0] quot;
	} div_state_t;

	div_state_t cur_r;
	div_state_t cur_nxt;

	always_comb begin
		logic [8:0] shifted;
		shifted = 9'h000;
		cur_nxt = cur_r;
		cur_nxt.done = 1'b0;
		if (dv.start && !cur_r.busy) begin
			// Caller guarantees high byte below divisor, so 8 bits suffice
			cur_nxt.busy = 1'b1;
			cur_nxt.count = 4'h0;
			cur_nxt.part = {1'b0, dv.dividend[15:8]};
			cur_nxt.low = dv.dividend[7:0];
			cur_nxt.divisor = dv.divisor;
			cur_nxt.quot = 8'h00;
		end else if (cur_r.busy) begin
			shifted = {cur_r.part[7:0], cur_r.low[7]};
			cur_nxt.low = {cur_r.low[6:0], 1'b0};
			if (shifted >= {1'b0, cur_r.divisor}) begin
				cur_nxt.part = shifted - {1'b0, cur_r.divisor};
				cur_nxt.quot = {cur_r.quot[6:0], 1'b1};
			end else begin
				cur_nxt.part = shifted;
				cur_nxt.quot = {cur_r.quot[6:0], 1'b0};
			end
			cur_nxt.count = cur_r.count + 4'h1;
			if (cur_nxt.count == byte_alu_pkg::DIV_STEPS) begin
				cur_nxt.busy = 1'b0;
				cur_nxt.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_r <= '0;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign dv.done = cur_r.done;
	assign dv.quotient = cur_r.quot;
	assign dv.remainder = cur_r.part[7:0];

endmodule : byte_divider

// >>> byte_alu.sv
// Byte ALU datapath with APB register access
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module byte_alu (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	typedef struct packed {
		byte_alu_pkg::alu_state_t state;
		logic [15:0]              dst;
		logic [15:0]              src;
		logic [7:0]               imm;
		logic [3:0]               condition_code_register;
		logic [4:0]               op;
		logic                     word;
		logic                     useImm;
		logic                     illegal;
		logic                     divErr;
		logic                     divStart;
		logic [31:0]              rdata;
	} alu_regs_t;

	alu_regs_t cur_r;
	alu_regs_t cur_nxt;

	div_if dv ();

	byte_divider u_div (
		.clk   (clk),
		.rst_n (rst_n),
		.dv    (dv)
	);

	function automatic logic [2:0] regSel(input logic [11:0] a);
		unique case (a)
			byte_alu_pkg::OFF_CTRL:   regSel = byte_alu_pkg::SEL_CTRL;
			byte_alu_pkg::OFF_DST:    regSel = byte_alu_pkg::SEL_DST;
			byte_alu_pkg::OFF_SRC:    regSel = byte_alu_pkg::SEL_SRC;
			byte_alu_pkg::OFF_IMM:    regSel = byte_alu_pkg::SEL_IMM;
			byte_alu_pkg::OFF_CCR:    regSel = byte_alu_pkg::SEL_CCR;
			byte_alu_pkg::OFF_STATUS: regSel = byte_alu_pkg::SEL_STATUS;
			default:                  regSel = byte_alu_pkg::SEL_NONE;
		endcase
	endfunction : regSel

	// Byte result flags: N and Z from value, V and C given
	function automatic logic [3:0] flagsOf(input logic [7:0] r,
		input logic v, input logic c);
		flagsOf = {r[7], (r == 8'h00), v, c};
	endfunction : flagsOf

	logic       access;
	logic       setup;
	logic [2:0] sel;

	assign access = psel && penable;
	assign setup = psel && !penable;
	assign sel = regSel(paddr);

	always_comb begin
		logic [7:0]  a;
		logic [7:0]  b;
		logic [8:0]  diff;
		logic [16:0] wdiff;
		logic [7:0]  res;
		logic [7:0]  adj;
		logic        cOld;
		logic        cNew;
		logic        busy;
		a = cur_r.dst[7:0];
		b = cur_r.useImm ? cur_r.imm : cur_r.src[7:0];
		diff = 9'h000;
		wdiff = 17'h00000;
		res = 8'h00;
		adj = 8'h00;
		cOld = cur_r.condition_code_register[byte_alu_pkg::CCR_C];
		cNew = 1'b0;
		busy = (cur_r.state != byte_alu_pkg::ST_IDLE);
		cur_nxt = cur_r;
		cur_nxt.divStart = 1'b0;

		// Read data is captured in the setup cycle, ready in the access phase
		if (setup && !pwrite) begin
			unique case (sel)
				byte_alu_pkg::SEL_CTRL: cur_nxt.rdata = {22'h000000,
					cur_r.useImm, cur_r.word, 3'h0, cur_r.op};
				byte_alu_pkg::SEL_DST:  cur_nxt.rdata = {16'h0000, cur_r.dst};
				byte_alu_pkg::SEL_SRC:  cur_nxt.rdata = {16'h0000, cur_r.src};
				byte_alu_pkg::SEL_IMM:  cur_nxt.rdata = {24'h000000, cur_r.imm};
				byte_alu_pkg::SEL_CCR:  cur_nxt.rdata = {28'h0000000, cur_r.condition_code_register};
				byte_alu_pkg::SEL_STATUS: cur_nxt.rdata = {29'h00000000,
					cur_r.divErr, cur_r.illegal, busy};
				default: cur_nxt.rdata = 32'h00000000;
			endcase
		end

		// Writes while an operation runs are dropped to keep operands stable
		if (access && pwrite && !busy) begin
			unique case (sel)
				byte_alu_pkg::SEL_CTRL: begin
					cur_nxt.op = pwdata[byte_alu_pkg::CTRL_OP_LSB +: 5];
					cur_nxt.word = pwdata[byte_alu_pkg::CTRL_WORD];
					cur_nxt.useImm = pwdata[byte_alu_pkg::CTRL_USE_IMM];
					cur_nxt.illegal = 1'b0;
					cur_nxt.divErr = 1'b0;
					cur_nxt.state = byte_alu_pkg::ST_EXEC;
				end
				byte_alu_pkg::SEL_DST: cur_nxt.dst = pwdata[15:0];
				byte_alu_pkg::SEL_SRC: cur_nxt.src = pwdata[15:0];
				byte_alu_pkg::SEL_IMM: cur_nxt.imm = pwdata[7:0];
				byte_alu_pkg::SEL_CCR: cur_nxt.condition_code_register = pwdata[3:0];
				default: ;
			endcase
		end

		unique case (cur_r.state)
			byte_alu_pkg::ST_IDLE: ;
			byte_alu_pkg::ST_EXEC: begin
				cur_nxt.state = byte_alu_pkg::ST_IDLE;
				unique case (cur_r.op)
					byte_alu_pkg::decimal_adjust_add: begin
						adj = 8'h00;
						cNew = cOld;
						if (a[3:0] > 4'h9) adj[3:0] = 4'h6;
						if (cOld || a > 8'h99) begin
							adj[7:4] = 4'h6;
							cNew = 1'b1;
						end
						res = a + adj;
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, 1'b0, cNew);
					end
					byte_alu_pkg::decimal_adjust_sub: begin
						// Without a half-carry, the low digit is judged by value
						adj = 8'h00;
						if (a[3:0] > 4'h9) adj[3:0] = 4'h6;
						if (cOld) adj[7:4] = 4'h6;
						res = a - adj;
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, 1'b0, cOld);
					end
					byte_alu_pkg::unsigned_multiply: begin
						// Widen first so the product keeps its high byte
						cur_nxt.dst = {8'h00, a} * {8'h00, cur_r.src[7:0]};
					end
					byte_alu_pkg::unsigned_divide: begin
						// Zero divisor or quotient above 8 bits leaves Rd as is
						if (cur_r.dst[15:8] >= cur_r.src[7:0]) begin
							cur_nxt.divErr = 1'b1;
							cur_nxt.condition_code_register[byte_alu_pkg::CCR_V] = 1'b1;
						end else begin
							cur_nxt.divStart = 1'b1;
							cur_nxt.state = byte_alu_pkg::ST_DIVIDE;
						end
					end
					byte_alu_pkg::compare_op: begin
						if (cur_r.word && cur_r.useImm) begin
							cur_nxt.illegal = 1'b1;
						end else if (cur_r.word) begin
							wdiff = {1'b0, cur_r.dst} - {1'b0, cur_r.src};
							cur_nxt.condition_code_register = {wdiff[15], (wdiff[15:0] == 16'h0000),
								(cur_r.dst[15] != cur_r.src[15]) &&
								(wdiff[15] != cur_r.dst[15]),
								wdiff[16]};
						end else begin
							diff = {1'b0, a} - {1'b0, b};
							cur_nxt.condition_code_register = flagsOf(diff[7:0],
								(a[7] != b[7]) && (diff[7] != a[7]),
								diff[8]);
						end
					end
					byte_alu_pkg::negate_op: begin
						res = 8'h00 - a;
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, (a == 8'h80), (a != 8'h00));
					end
					byte_alu_pkg::and_op, byte_alu_pkg::or_op,
					byte_alu_pkg::xor_op, byte_alu_pkg::not_op: begin
						if (cur_r.op == byte_alu_pkg::and_op) res = a & b;
						else if (cur_r.op == byte_alu_pkg::or_op) res = a | b;
						else if (cur_r.op == byte_alu_pkg::xor_op) res = a ^ b;
						else res = ~a;
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, 1'b0, cOld);
					end
					byte_alu_pkg::arith_shift_left: begin
						res = {a[6:0], 1'b0};
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, a[7] ^ a[6], a[7]);
					end
					byte_alu_pkg::arith_shift_right: begin
						res = {a[7], a[7:1]};
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, 1'b0, a[0]);
					end
					byte_alu_pkg::logic_shift_left: begin
						res = {a[6:0], 1'b0};
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, 1'b0, a[7]);
					end
					byte_alu_pkg::logic_shift_right: begin
						res = {1'b0, a[7:1]};
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, 1'b0, a[0]);
					end
					byte_alu_pkg::rotate_left: begin
						res = {a[6:0], a[7]};
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, 1'b0, a[7]);
					end
					byte_alu_pkg::rotate_right: begin
						res = {a[0], a[7:1]};
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, 1'b0, a[0]);
					end
					byte_alu_pkg::rotate_carry_left: begin
						res = {a[6:0], cOld};
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, 1'b0, a[7]);
					end
					byte_alu_pkg::rotate_carry_right: begin
						res = {cOld, a[7:1]};
						cur_nxt.dst[7:0] = res;
						cur_nxt.condition_code_register = flagsOf(res, 1'b0, a[0]);
					end
					default: cur_nxt.illegal = 1'b1;
				endcase
			end
			byte_alu_pkg::ST_DIVIDE: begin
				if (dv.done) begin
					cur_nxt.dst = {dv.remainder, dv.quotient};
					cur_nxt.condition_code_register = flagsOf(dv.quotient, 1'b0, cOld);
					cur_nxt.state = byte_alu_pkg::ST_IDLE;
				end
			end
			default: cur_nxt.state = byte_alu_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_r.state <= byte_alu_pkg::ST_IDLE;
			cur_r.dst <= byte_alu_pkg::RST_DST;
			cur_r.src <= byte_alu_pkg::RST_SRC;
			cur_r.imm <= byte_alu_pkg::RST_IMM;
			cur_r.condition_code_register <= byte_alu_pkg::RST_CCR;
			cur_r.op <= byte_alu_pkg::RST_OP;
			cur_r.word <= 1'b0;
			cur_r.useImm <= 1'b0;
			cur_r.illegal <= 1'b0;
			cur_r.divErr <= 1'b0;
			cur_r.divStart <= 1'b0;
			cur_r.rdata <= 32'h00000000;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// Divisor is the source byte; dividend is the full destination word
	assign dv.start = cur_r.divStart;
	assign dv.dividend = cur_r.dst;
	assign dv.divisor = cur_r.src[7:0];

	// Zero-wait slave: read data was latched in the setup cycle
	assign pready = 1'b1;
	assign pslverr = access && (sel == byte_alu_pkg::SEL_NONE);
	assign prdata = cur_r.rdata;

endmodule : byte_alu

// >>> byte_alu_asserts.sv
// Checker of the byte ALU register port
`timescale 1ns/1ps
module byte_alu_asserts (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// APB slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	logic mapped;
	logic rdAcc;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= 12'h014;
	assign rdAcc = psel && penable && !pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_ready_always: assert property (pready)
		else $error("pready low");
	a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
		else $error("no error on unmapped access");
	a_err_cause: assert property (pslverr |-> psel && penable && !mapped)
		else $error("spurious slave error");
	a_unmapped_zero: assert property (rdAcc && !mapped |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	// Read data only moves at a read setup edge
	a_rdata_holds: assert property (!(psel && !penable && !pwrite)
		|=> $stable(prdata)) else $error("read data moved");
	a_ccr_narrow: assert property (
		rdAcc && paddr == byte_alu_pkg::OFF_CCR |-> prdata[31:4] == 28'h0)
		else $error("flag word too wide");
	a_dst_narrow: assert property (
		rdAcc && paddr == byte_alu_pkg::OFF_DST |-> prdata[31:16] == 16'h0)
		else $error("destination word too wide");
	a_status_narrow: assert property (
		rdAcc && paddr == byte_alu_pkg::OFF_STATUS |-> prdata[31:3] == 29'h0)
		else $error("status word too wide");
	c_unmapped: cover property (rdAcc && !mapped);
	c_launch: cover property (psel && penable && pwrite
		&& paddr == byte_alu_pkg::OFF_CTRL);
	c_flags: cover property (rdAcc && paddr == byte_alu_pkg::OFF_CCR);
endmodule : byte_alu_asserts

bind byte_alu byte_alu_asserts chk (.clk, .rst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr);

// >>> op_issuer.sv
// Sequencer model issuing operations over APB
`timescale 1ns/1ps
module op_issuer (
	// Clock
	input wire logic        clk,
	// APB master
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic     [11:0] paddr,
	output logic     [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines show garbage, not the old request
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge clk);
	endtask : xfer
endmodule : op_issuer

// >>> byte_alu_test.sv
// Self-checking bench of the byte ALU
`timescale 1ns/1ps
module byte_alu_test;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	typedef struct {logic [31:0] val; logic [31:0] mask;} note_t;
	note_t       notes[$];
	int          failures = 0;
	int          num_checks = 0;

	byte_alu dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);
	op_issuer iss (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report

	always @(posedge clk) if (psel && penable && !pwrite && notes.size() > 0) begin
		note_t n;
		n = notes.pop_front();
		if (n.mask != 32'h0) check("read data", prdata & n.mask, n.val & n.mask);
	end

	// Only the six word offsets are mapped
	always @(posedge clk) if (psel && penable)
		check("slave error", {31'h0, pslverr},
			{31'h0, paddr[1:0] != 2'h0 || paddr > 12'h014});

	task automatic wr(logic [11:0] a, logic [31:0] d);
		logic [31:0] q;
		iss.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m);
		logic [31:0] q;
		notes.push_back('{e, m});
		iss.xfer(1'b0, a, 32'h0, q);
	endtask : rd

	task automatic wait_idle();
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			notes.push_back('{32'h0, 32'h0});
			iss.xfer(1'b0, byte_alu_pkg::OFF_STATUS, 32'h0, q);
			n++;
		end while (q[0] !== 1'b0 && n < 40);
	endtask : wait_idle

	// Returns {destination, flags}
	function automatic logic [19:0] model(logic [4:0] op, logic w, logic ui,
		logic [15:0] d, logic [15:0] s, logic [7:0] im, logic [3:0] f);
		logic [7:0] b, x, r;
		logic [8:0] t;
		logic [16:0] u;
		logic c;
		b = d[7:0];
		x = ui ? im : s[7:0];
		c = f[0];
		r = b;
		model = {d, f[3:2], 1'b0, c};
		case (op)
			5'h00: begin
				r = b + (b[3:0] > 4'h9 ? 8'h06 : 8'h00) + (c || b > 8'h99 ? 8'h60 : 8'h00);
				model[0] = c || b > 8'h99;
			end
			5'h01: r = b - (b[3:0] > 4'h9 ? 8'h06 : 8'h00) - (c ? 8'h60 : 8'h00);
			5'h02: return {16'(b) * 16'(s[7:0]), f};
			5'h03: begin
				if (d[15:8] >= s[7:0]) return {d, f[3:2], 1'b1, c};
				r = 8'(d / s[7:0]);
				return {8'(d % s[7:0]), r, r[7], r == 8'h0, 1'b0, c};
			end
			5'h04: begin
				if (w) begin
					u = {1'b0, d} - {1'b0, s};
					return {d, u[15], u[15:0] == 16'h0, (d[15] ^ s[15]) & (d[15] ^ u[15]), u[16]};
				end
				t = {1'b0, b} - {1'b0, x};
				return {d, t[7], t[7:0] == 8'h0, (b[7] ^ x[7]) & (b[7] ^ t[7]), t[8]};
			end
			5'h05: begin
				r = 8'h00 - b;
				model[1:0] = {b == 8'h80, b != 8'h00};
			end
			5'h06: r = b & x;
			5'h07: r = b | x;
			5'h08: r = b ^ x;
			5'h09: r = ~b;
			5'h0a: {model[0], r, model[1]} = {b, 1'b0, b[7] ^ b[6]};
			5'h0b: {r, model[0]} = {b[7], b};
			5'h0c: {model[0], r} = {b, 1'b0};
			5'h0d: {r, model[0]} = {1'b0, b};
			5'h0e: {model[0], r} = {b, b[7]};
			5'h0f: {r, model[0]} = {b[0], b};
			5'h10: {model[0], r} = {b, c};
			default: {r, model[0]} = {c, b};
		endcase
		model[11:2] = {r, r[7], r == 8'h0};
	endfunction : model

	initial begin
		logic [4:0] op;
		logic [15:0] d, s;
		logic [7:0] im;
		logic [3:0] f;
		logic w, ui;
		logic [19:0] e;
		rst_n = 1'b0;
		void'($urandom(67));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int k = 0; k < 7; k++) rd(12'(4 * k), 32'h0, 32'hffffffff);
		wr(12'h018, 32'hffffffff);
		$display("reset values and unmapped access done");
		for (int i = 0; i < 54; i++) begin
			op = 5'(i % 18);
			ui = 1'($urandom);
			w = op == 5'h04 && !ui && 1'($urandom);
			{d, s} = $urandom;
			{im, f} = 12'($urandom);
			if (op == 5'h03 && i < 18) {d[15], s[7]} = 2'b01;
			wr(byte_alu_pkg::OFF_DST, {16'h0, d});
			wr(byte_alu_pkg::OFF_SRC, {16'h0, s});
			wr(byte_alu_pkg::OFF_IMM, {24'h0, im});
			wr(byte_alu_pkg::OFF_CCR, {28'h0, f});
			wr(byte_alu_pkg::OFF_CTRL, {22'h0, ui, w, 3'h0, op});
			// A write during a running divide must be dropped
			// A refused divide ends at once, so only a running one is tried
			if (op == 5'h03 && d[15:8] < s[7:0])
				wr(byte_alu_pkg::OFF_DST, 32'h0000ffff);
			wait_idle();
			e = model(op, w, ui, d, s, im, f);
			rd(byte_alu_pkg::OFF_DST, {16'h0, e[19:4]}, 32'hffffffff);
			rd(byte_alu_pkg::OFF_CCR, {28'h0, e[3:0]}, op < 5'h02 ? 32'h3 : 32'hf);
			rd(byte_alu_pkg::OFF_STATUS, {29'h0, op == 5'h03 && d[15:8] >= s[7:0], 2'h0}, 32'h6);
		end
		$display("operation sweep done");
		for (int k = 0; k < 2; k++) begin
			wr(byte_alu_pkg::OFF_CCR, 32'h5);
			wr(byte_alu_pkg::OFF_CTRL, k ? 32'h12 : 32'h304);
			wait_idle();
			rd(byte_alu_pkg::OFF_STATUS, 32'h2, 32'h6);
			rd(byte_alu_pkg::OFF_CCR, 32'h5, 32'hffffffff);
		end
		$display("refused operations done");
		final_report();
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		final_report();
	end
endmodule : byte_alu_test
